// ==== hdl/reg_store.sv ====
// Small register store with byte enables and registered read data
`timescale 1ns/1ps
module reg_store #(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [ADDR_W-1:0] raddr,
	output logic [DATA_W-1:0] rdata
);
	import twi_pkg::*;

	localparam int HALF = DATA_W / 2;

	logic [DATA_W-1:0] mem_r [2**ADDR_W];

	// Write port, each half gated by its own enable
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 2**ADDR_W; i++)
				mem_r[i] <= REG_RESET;
		end
		else if (we)
		begin
			if (be[1])
				mem_r[waddr][DATA_W-1:HALF] <= wdata[DATA_W-1:HALF];
			if (be[0])
				mem_r[waddr][HALF-1:0] <= wdata[HALF-1:0];
		end
	end

	// Read data from a register so the shifter sees a clean word
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata <= REG_RESET;
		else
			rdata <= mem_r[raddr];
	end

endmodule : reg_store

// ==== hdl/twi_pkg.sv ====
// Constants, types and timing for the two-wire target framing block
package twi_pkg;

	// Bus address: base value plus the address-select pin code
	localparam logic [6:0] BASE_ADDR = 7'h48;
	localparam int ADDR_SEL_W = 2;

	// Register store shape
	localparam int REG_W = 16;
	localparam int BYTE_W = 8;
	localparam int PTR_W_DEF = 2;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam int SAMPLE_IDX = 0;

	// Bit count of one byte on the wire
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Byte enables: bit 1 is the most significant byte
	localparam logic [1:0] BE_MSB = 2'h2;
	localparam logic [1:0] BE_WORD = 2'h3;

	// Strap capture waits this many link cycles after reset release
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// Low-clock timeout in ms, counted on the link clock
	localparam int TIMEOUT_MS = 30;
	localparam int LINK_PERIOD_NS = 30;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / LINK_PERIOD_NS;

	// Framing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_ACK,
		ST_RDATA,
		ST_RACK,
		ST_IGNORE
	} state_t;

endpackage : twi_pkg

// ==== hdl/two_wire_slave_bus_framing.sv ====
// Two-wire bus target framing: conditions, acknowledge, register read/write
`timescale 1ns/1ps
module two_wire_slave_bus_framing #(
	parameter int TIMEOUT_CYCLES = twi_pkg::TIMEOUT_CYC,
	parameter int PTR_W = twi_pkg::PTR_W_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [twi_pkg::ADDR_SEL_W-1:0] address_select_pin,
	input wire logic sample_valid,
	input wire logic [twi_pkg::REG_W-1:0] sample_data,
	output logic reg_wr,
	output logic [PTR_W-1:0] reg_wr_idx,
	output logic [twi_pkg::REG_W-1:0] reg_wr_data,
	output logic reg_wr_msb_only
);
	import twi_pkg::*;

	logic [1:0] lrst_sync_r;
	logic lrst_n;
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	logic [ADDR_SEL_W-1:0] sel_m_r, sel_s_r;
	logic [1:0] strap_cnt_r;
	logic [6:0] own_addr_r;
	logic [31:0] tmo_cnt_r;
	logic tmo_r;
	logic scl_rise, scl_fall, start_det, stop_det;
	state_t state_r, after_r;
	logic [3:0] bit_cnt_r;
	logic [BYTE_W-1:0] sh_r, tx_r, msb_r, nb;
	logic msb_pend_r, lsb_next_r, sda_oe_r;
	logic [PTR_W-1:0] ptr_r, wr_idx_r;
	logic wr_en_r, wr_tgl_r;
	logic [1:0] wr_be_r;
	logic [REG_W-1:0] wr_data_r, rd_data;
	logic samp_tgl_r;
	logic [REG_W-1:0] samp_data_r;
	logic [2:0] samp_sync_r, wev_sync_r;
	logic samp_pend_r;
	logic mem_we;
	logic [1:0] mem_be;
	logic [PTR_W-1:0] mem_waddr;
	logic [REG_W-1:0] mem_wdata;

	// Pick the byte to send: high half first, then low half
	function automatic logic [BYTE_W-1:0] pick_byte(input logic [REG_W-1:0] w, input logic lsb);
		pick_byte = lsb ? w[BYTE_W-1:0] : w[REG_W-1:BYTE_W];
	endfunction : pick_byte

	// Reset into the link domain through two stages
	always_ff @(posedge link_clk)
		lrst_sync_r <= {lrst_sync_r[0], rst_n};
	assign lrst_n = lrst_sync_r[1];

	// Pin synchronisers; the _d stage is the previous sample for edges
	always_ff @(posedge link_clk)
	begin
		if (!lrst_n)
		begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
		end
		else
		begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	// Edge and condition detection on synchronised levels only
	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// Address strap caught a few cycles after release, once synchronised
	always_ff @(posedge link_clk)
	begin
		if (!lrst_n)
		begin
			sel_m_r <= '0;
			sel_s_r <= '0;
			strap_cnt_r <= '0;
			own_addr_r <= BASE_ADDR;
		end
		else
		begin
			sel_m_r <= address_select_pin;
			sel_s_r <= sel_m_r;
			if (strap_cnt_r != STRAP_WAIT)
				strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == STRAP_WAIT - 2'h1)
				own_addr_r <= BASE_ADDR + 7'(sel_s_r);
		end
	end

	// Low-clock watchdog; saturates so it fires once per stuck period
	always_ff @(posedge link_clk)
	begin
		if (!lrst_n || scl_s_r)
		begin
			tmo_cnt_r <= '0;
			tmo_r <= 1'b0;
		end
		else
		begin
			if (tmo_cnt_r != 32'(TIMEOUT_CYCLES))
				tmo_cnt_r <= tmo_cnt_r + 32'h1;
			tmo_r <= (tmo_cnt_r == 32'(TIMEOUT_CYCLES - 1));
		end
	end

	assign nb = pick_byte(rd_data, lsb_next_r);

	// Framing engine: byte capture, acknowledge, transmit
	always_ff @(posedge link_clk)
	begin
		wr_en_r <= 1'b0;
		if (!lrst_n)
		begin
			state_r <= ST_IDLE;
			after_r <= ST_IDLE;
			bit_cnt_r <= '0;
			sh_r <= '0;
			tx_r <= '0;
			msb_r <= '0;
			msb_pend_r <= 1'b0;
			lsb_next_r <= 1'b0;
			sda_oe_r <= 1'b0;
			ptr_r <= '0;
			wr_idx_r <= '0;
			wr_be_r <= '0;
			wr_data_r <= '0;
		end
		else if (start_det || stop_det || tmo_r)
		begin
			// Any of start, stop or timeout closes the transfer and frees the line
			sda_oe_r <= 1'b0;
			bit_cnt_r <= '0;
			state_r <= (start_det && !tmo_r) ? ST_ADDR : ST_IDLE;
			msb_pend_r <= 1'b0;
			// A lone first data byte lands in the high half only
			if (msb_pend_r && !tmo_r)
			begin
				wr_en_r <= (ptr_r != PTR_W'(SAMPLE_IDX));
				wr_be_r <= BE_MSB;
				wr_data_r <= {msb_r, BYTE_W'(0)};
				wr_idx_r <= ptr_r;
			end
		end
		else
		begin
			case (state_r)
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					if (scl_rise)
					begin
						sh_r <= {sh_r[BYTE_W-2:0], sda_s_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (scl_fall && bit_cnt_r == BYTE_BITS)
					begin
						bit_cnt_r <= '0;
						state_r <= ST_ACK;
						sda_oe_r <= 1'b1;
						after_r <= ST_WDATA;
						if (state_r == ST_ADDR)
						begin
							lsb_next_r <= 1'b0;
							if (sh_r[BYTE_W-1:1] != own_addr_r)
							begin
								state_r <= ST_IGNORE;
								sda_oe_r <= 1'b0;
							end
							else
								after_r <= sh_r[0] ? ST_RDATA : ST_PTR;
						end
						else if (state_r == ST_PTR)
							ptr_r <= sh_r[PTR_W-1:0];
						else if (!msb_pend_r)
						begin
							msb_r <= sh_r;
							msb_pend_r <= 1'b1;
						end
						else
						begin
							// Second byte completes the word; index 0 is read-only
							msb_pend_r <= 1'b0;
							wr_en_r <= (ptr_r != PTR_W'(SAMPLE_IDX));
							wr_be_r <= BE_WORD;
							wr_data_r <= {msb_r, sh_r};
							wr_idx_r <= ptr_r;
						end
					end
				end
				ST_ACK:
				begin
					// Held from one falling edge to the next covers the high phase
					if (scl_fall)
					begin
						state_r <= after_r;
						bit_cnt_r <= '0;
						if (after_r == ST_RDATA)
						begin
							tx_r <= nb;
							sda_oe_r <= ~nb[BYTE_W-1];
							lsb_next_r <= ~lsb_next_r;
						end
						else
							sda_oe_r <= 1'b0;
					end
				end
				ST_RDATA:
				begin
					if (scl_rise)
						bit_cnt_r <= bit_cnt_r + 4'h1;
					else if (scl_fall)
					begin
						if (bit_cnt_r == BYTE_BITS)
						begin
							sda_oe_r <= 1'b0;
							bit_cnt_r <= '0;
							state_r <= ST_RACK;
						end
						else
						begin
							tx_r <= {tx_r[BYTE_W-2:0], 1'b0};
							sda_oe_r <= ~tx_r[BYTE_W-2];
						end
					end
				end
				ST_RACK:
				begin
					// High at the ninth rise is a not-acknowledge: stay off the line
					if (scl_rise)
					begin
						state_r <= sda_s_r ? ST_IGNORE : ST_ACK;
						after_r <= ST_RDATA;
					end
				end
				ST_IDLE, ST_IGNORE:
					sda_oe_r <= 1'b0;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Open-drain pin: only ever pulls low
	always_ff @(posedge link_clk)
	begin
		sda_o <= 1'b0;
		sda_oe <= lrst_n & sda_oe_r;
	end

	// Core side: hold the new sample and flag it by a toggle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			samp_tgl_r <= 1'b0;
			samp_data_r <= REG_RESET;
		end
		else if (sample_valid)
		begin
			samp_tgl_r <= ~samp_tgl_r;
			samp_data_r <= sample_data;
		end
	end

	// Link side: sample word is stable while its toggle crosses
	always_ff @(posedge link_clk)
	begin
		if (!lrst_n)
		begin
			samp_sync_r <= '0;
			samp_pend_r <= 1'b0;
		end
		else
		begin
			samp_sync_r <= {samp_sync_r[1:0], samp_tgl_r};
			if (samp_sync_r[2] != samp_sync_r[1])
				samp_pend_r <= 1'b1;
			else if (!wr_en_r)
				samp_pend_r <= 1'b0;
		end
	end

	// Bus writes win the port; a pending sample retries next cycle
	assign mem_we = wr_en_r | samp_pend_r;
	assign mem_be = wr_en_r ? wr_be_r : BE_WORD;
	assign mem_waddr = wr_en_r ? wr_idx_r : PTR_W'(SAMPLE_IDX);
	assign mem_wdata = wr_en_r ? wr_data_r : samp_data_r;

	reg_store #(
		.DATA_W(REG_W),
		.ADDR_W(PTR_W)
	) u_store (
		.clk(link_clk),
		.rst_n(lrst_n),
		.we(mem_we),
		.be(mem_be),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(ptr_r),
		.rdata(rd_data)
	);

	// Write events cross to the core by toggle; data holds until the next write
	always_ff @(posedge link_clk)
	begin
		if (!lrst_n)
			wr_tgl_r <= 1'b0;
		else if (wr_en_r)
			wr_tgl_r <= ~wr_tgl_r;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wev_sync_r <= '0;
			reg_wr <= 1'b0;
			reg_wr_idx <= '0;
			reg_wr_data <= REG_RESET;
			reg_wr_msb_only <= 1'b0;
		end
		else
		begin
			wev_sync_r <= {wev_sync_r[1:0], wr_tgl_r};
			reg_wr <= (wev_sync_r[2] != wev_sync_r[1]);
			if (wev_sync_r[2] != wev_sync_r[1])
			begin
				reg_wr_idx <= wr_idx_r;
				reg_wr_data <= wr_data_r;
				reg_wr_msb_only <= (wr_be_r == BE_MSB);
			end
		end
	end

endmodule : two_wire_slave_bus_framing

// ==== testbench/twi_master_model.sv ====
// Bus master model: drives SCL and pulls SDA on the shared wire
`timescale 1ns/1ps
module twi_master_model (
	input wire logic clk,
	input wire logic sda_w,
	output logic scl_o,
	output logic sda_low
);
	// Both lines released while idle
	initial
	begin
		scl_o = 1'b1;
		sda_low = 1'b0;
	end

	task automatic hp(input int n);
		repeat (n) @(negedge clk);
	endtask : hp

	// Let SDA return to its pull-up while SCL stays low, as a transmitter awaiting an acknowledge
	task automatic release_sda();
		sda_low = 1'b0;
	endtask : release_sda

	// Start or repeated start; phases of 14 cycles keep the sync latency inside
	task automatic start();
		sda_low = 1'b0;
		hp(14);
		scl_o = 1'b1;
		hp(14);
		sda_low = 1'b1;
		hp(14);
		scl_o = 1'b0;
	endtask : start

	task automatic stop();
		sda_low = 1'b1;
		hp(14);
		scl_o = 1'b1;
		hp(14);
		sda_low = 1'b0;
		hp(14);
	endtask : stop

	// A low that does not last the whole high phase reads back as high
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		hp(14);
		scl_o = 1'b1;
		hp(7);
		r = sda_w;
		hp(7);
		r = r | sda_w;
		scl_o = 1'b0;
	endtask : bit_io

	task automatic xfer(input logic [7:0] wb, input logic ab, output logic [7:0] rb,
		output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_io(wb[i], rb[i]);
		bit_io(ab, ak);
	endtask : xfer
endmodule : twi_master_model

// ==== testbench/two_wire_slave_bus_framing_checker.sv ====
// Port-level assertions for the two-wire target framing block
`timescale 1ns/1ps
module two_wire_slave_bus_framing_checker #(
	parameter int TIMEOUT_CYCLES = 200,
	parameter int PTR_W = 2
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [twi_pkg::ADDR_SEL_W-1:0] address_select_pin,
	input wire logic sample_valid,
	input wire logic [twi_pkg::REG_W-1:0] sample_data,
	input wire logic reg_wr,
	input wire logic [PTR_W-1:0] reg_wr_idx,
	input wire logic [twi_pkg::REG_W-1:0] reg_wr_data,
	input wire logic reg_wr_msb_only
);
	int low_cnt;

	// Length of the current SCL low phase; saturates so it never wraps
	always_ff @(posedge link_clk)
	begin
		if (!rst_n || scl_i)
			low_cnt <= 0;
		else if (low_cnt < TIMEOUT_CYCLES + 16)
			low_cnt <= low_cnt + 1;
	end

	property p_sda_o_low;
		@(posedge link_clk) disable iff (!rst_n) sda_o == 1'b0;
	endproperty
	a_sda_o_low: assert property (p_sda_o_low)
		else $error("sda_o not low");
	property p_oe_steady;
		@(posedge link_clk) disable iff (!rst_n) scl_i && $past(scl_i) |-> $stable(sda_oe);
	endproperty
	a_oe_steady: assert property (p_oe_steady)
		else $error("sda_oe moved while SCL high");
	property p_oe_change_low;
		@(posedge link_clk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_i && !$past(scl_i, 3);
	endproperty
	a_oe_change_low: assert property (p_oe_change_low)
		else $error("sda_oe moved outside SCL low");
	property p_timeout;
		@(posedge link_clk) disable iff (!rst_n) low_cnt > TIMEOUT_CYCLES + 8 |-> !sda_oe;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("SDA held after SCL timeout");
	property p_wr_pulse;
		@(posedge core_clk) disable iff (!rst_n) reg_wr |=> !reg_wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("reg_wr longer than one cycle");
	property p_wr_idx;
		@(posedge core_clk) disable iff (!rst_n) reg_wr |-> reg_wr_idx != '0;
	endproperty
	a_wr_idx: assert property (p_wr_idx)
		else $error("write landed in the sample word");
	property p_msb_only;
		@(posedge core_clk) disable iff (!rst_n) reg_wr && reg_wr_msb_only |-> reg_wr_data[7:0] == 8'h00;
	endproperty
	a_msb_only: assert property (p_msb_only)
		else $error("high-byte write carries a low byte");
	property p_wr_hold;
		@(posedge core_clk) disable iff (!rst_n)
			!reg_wr |-> $stable(reg_wr_data) && $stable(reg_wr_idx) && $stable(reg_wr_msb_only);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write outputs moved without reg_wr");
endmodule : two_wire_slave_bus_framing_checker

bind two_wire_slave_bus_framing two_wire_slave_bus_framing_checker #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.PTR_W(PTR_W)
) i_checker (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
	.sample_valid(sample_valid), .sample_data(sample_data), .reg_wr(reg_wr),
	.reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .reg_wr_msb_only(reg_wr_msb_only));

// ==== testbench/two_wire_slave_bus_framing_test.sv ====
// Self-checking bench for the two-wire target framing block
`timescale 1ns/1ps
module two_wire_slave_bus_framing_test;
	import twi_pkg::*;
	typedef struct {logic [7:0] ptr; int n; logic [15:0] d; logic msb; logic [15:0] rd;} row_t;
	row_t rows [4] = '{'{8'h01, 2, 16'h1234, 1'b0, 16'h1234},
		'{8'h02, 2, 16'h5678, 1'b0, 16'h5678}, '{8'h06, 1, 16'hAB00, 1'b1, 16'hAB78},
		'{8'h03, 4, 16'hC3A5, 1'b0, 16'hC3A5}};
	logic core_clk, link_clk, rst_n, m_scl, m_low, sample_valid, ack;
	logic sda_o, sda_oe, reg_wr, reg_wr_msb_only;
	logic [1:0] strap, reg_wr_idx;
	logic [15:0] sample_data, reg_wr_data;
	logic [7:0] rb;
	int mismatches = 0, cmp_count = 0, cyc = 0, wr_cnt = 0, w0;
	wire sda_w = (sda_oe ? sda_o : 1'b1) & ~m_low;

	two_wire_slave_bus_framing #(.TIMEOUT_CYCLES(200), .PTR_W(2)) i_two_wire_slave_bus_framing (
		.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(m_scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(strap),
		.sample_valid(sample_valid), .sample_data(sample_data), .reg_wr(reg_wr),
		.reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .reg_wr_msb_only(reg_wr_msb_only));
	twi_master_model i_twi_master_model (.clk(core_clk), .sda_w(sda_w), .scl_o(m_scl),
		.sda_low(m_low));

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Link clock at 30 ns with an unrelated phase
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// Count landed writes and cut a hang short
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (reg_wr)
			wr_cnt <= wr_cnt + 1;
		if (cyc == 90000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Held eight cycles so the link side also sees at least five reset edges
	task automatic do_reset(input logic [1:0] c);
		rst_n = 1'b0;
		strap = c;
		repeat (8) @(negedge core_clk);
		check({15'h0, sda_oe}, 16'h0000);
		rst_n = 1'b1;
		repeat (20) @(negedge core_clk);
	endtask : do_reset
	task automatic wr(input logic [7:0] b, input logic exp_ack);
		i_twi_master_model.xfer(b, 1'b1, rb, ack);
		check({15'h0, ack}, {15'h0, exp_ack});
	endtask : wr
	task automatic wr_xfer(input logic [7:0] p, input int n, input logic [15:0] d);
		i_twi_master_model.start();
		wr({BASE_ADDR, 1'b0}, 1'b0);
		wr(p, 1'b0);
		for (int k = 0; k < n; k++)
			wr(k[0] ? d[7:0] : d[15:8], 1'b0);
	endtask : wr_xfer
	// Read n bytes after a repeated start, the last one refused
	task automatic rd(input int n, input logic [15:0] w);
		i_twi_master_model.start();
		wr({BASE_ADDR, 1'b1}, 1'b0);
		for (int k = 0; k < n; k++)
		begin
			i_twi_master_model.xfer(8'hFF, k == n - 1, rb, ack);
			check({8'h00, rb}, {8'h00, k[0] ? w[7:0] : w[15:8]});
		end
		repeat (10) @(negedge core_clk);
		check({15'h0, sda_oe}, 16'h0000);
		i_twi_master_model.stop();
	endtask : rd
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		do_reset(2'h0);
		foreach (rows[i])
		begin
			w0 = wr_cnt;
			wr_xfer(rows[i].ptr, rows[i].n, rows[i].d);
			rd(2, rows[i].rd);
			check(16'(wr_cnt - w0), 16'((rows[i].n + 1) / 2));
			check({14'h0, reg_wr_idx}, {14'h0, rows[i].ptr[1:0]});
			check(reg_wr_data, rows[i].d);
			check({15'h0, reg_wr_msb_only}, {15'h0, rows[i].msb});
			$display("Row %0d done", i);
		end
		// Sample word is read-only from the bus; a long read wraps MSB, LSB, MSB
		sample_data = 16'hBEEF;
		sample_valid = 1'b1;
		@(negedge core_clk);
		sample_valid = 1'b0;
		w0 = wr_cnt;
		wr_xfer(8'h00, 2, 16'h1111);
		rd(3, 16'hBEEF);
		check(16'(wr_cnt - w0), 16'h0000);
		$display("Sample test done");
		// SCL stuck low during the address acknowledge
		i_twi_master_model.start();
		for (int k = 7; k >= 0; k--)
			i_twi_master_model.bit_io(k == 0 ? 1'b0 : BASE_ADDR[k - 1], rb[k]);
		// The last address bit is a low; let go so only the target can hold SDA
		i_twi_master_model.release_sda();
		repeat (20) @(negedge core_clk);
		check({15'h0, sda_oe}, 16'h0001);
		repeat (400) @(negedge core_clk);
		check({15'h0, sda_w}, 16'h0001);
		i_twi_master_model.stop();
		i_twi_master_model.start();
		wr({BASE_ADDR, 1'b0}, 1'b0);
		i_twi_master_model.stop();
		$display("Timeout test done");
		// Each strap code answers its own address only
		for (int c = 0; c < 4; c++)
		begin
			do_reset(2'(c));
			i_twi_master_model.start();
			wr({BASE_ADDR + 7'(c), 1'b0}, 1'b0);
			i_twi_master_model.start();
			wr({BASE_ADDR + 7'((c + 1) % 4), 1'b0}, 1'b1);
			i_twi_master_model.stop();
		end
		$display("Strap test done");
		report_and_stop();
	end
endmodule : two_wire_slave_bus_framing_test
